// ### hw/dtt_pkg.sv
// Shared constants and types of the debug trigger and trace block
package dtt_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TRIG = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_CMPA = 8'h0c;
   localparam logic [7:0] OFS_CMPB = 8'h10;
   localparam logic [7:0] OFS_FIFO = 8'h14;
   // Debug control register fields
   localparam int CTL_EN = 7;
   localparam int CTL_ARM = 6;
   localparam int CTL_TAG = 5;
   localparam int CTL_BRK = 4;
   localparam int CTL_RWA = 3;
   localparam int CTL_RWAEN = 2;
   localparam int CTL_RWB = 1;
   localparam int CTL_RWBEN = 0;
   // Trigger configuration fields
   localparam int TRG_QUAL = 7;
   localparam int TRG_BEGIN = 6;
   localparam logic [7:0] TRG_WMASK = 8'hcf;
   // Trace status fields
   localparam int STS_AF = 7;
   localparam int STS_BF = 6;
   localparam int STS_ARMED_FLAG = 5;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] TRIG_RST = 8'h00;
   localparam logic [15:0] CMP_RST = 16'h0000;
   // Trace depth and count limits
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] CNT_FULL = 4'h8;
   // Trigger modes
   localparam logic [3:0] MODE_A = 4'h0;
   localparam logic [3:0] MODE_A_OR_B = 4'h1;
   localparam logic [3:0] MODE_A_THEN_B = 4'h2;
   localparam logic [3:0] MODE_EV_B = 4'h3;
   localparam logic [3:0] MODE_A_EV_B = 4'h4;
   localparam logic [3:0] MODE_A_AND_D = 4'h5;
   localparam logic [3:0] MODE_A_NOT_D = 4'h6;
   localparam logic [3:0] MODE_INSIDE = 4'h7;
   localparam logic [3:0] MODE_OUTSIDE = 4'h8;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Run state
   typedef enum logic [2:0] {
      RUN_IDLE = 3'b001,
      RUN_SEEK = 3'b010,
      RUN_STORE = 3'b100
   } dtt_run_e;
endpackage

// ### hw/dtt_addr_cmp.sv
// Address comparator with optional read/write qualification on the equality hit only
`timescale 1ns/100ps
module dtt_addr_cmp (
   input wire logic [15:0] cmp_val,
   input wire logic [15:0] addr,
   input wire logic valid,
   input wire logic rw,
   input wire logic rw_en,
   input wire logic rw_val,
   output logic hit,
   output logic at_or_above,
   output logic at_or_below
);
   logic rw_ok;

   // Direction filter, then equality and range sides
   always_comb
   begin
      rw_ok = !rw_en || (rw == rw_val);
      hit = valid && rw_ok && (addr == cmp_val);
      at_or_above = valid && (addr >= cmp_val);
      at_or_below = valid && (addr <= cmp_val);
   end
endmodule // dtt_addr_cmp

// ### hw/dtt_trace_top.sv
// Debug trigger, trace run and status logic behind an AXI4-Lite slave
// Functional notes
// (R1) Trigger config always readable; writes ignored while armed.
// (R2) Trigger config bits 4 and 5 always read zero.
// (R3) Qualify bit set: trigger only when opcode at address executes.
// (R4) Bit 6 clear: circular fill until trigger; set: trigger starts store.
// (R5) Event-only modes ignore bit 6 and run as begin traces.
// (R6) Mode decode 0000..0110 as listed; 1001..1111 never trigger.
// (R7) Mode 0111 inside A..B inclusive; 1000 below A or above B.
// (R8) Trace status is read-only; writes change nothing.
// (R9) Match A flag cleared at run start, set on A match while armed.
// (R10) Match B flag cleared at run start, set on B match while armed.
// (R11) Armed flag mirrors arm bit while module enabled.
// (R12) Writing arm 1 while enabled arms; run end clears it.
// (R13) Run ends on FIFO full (begin) or trigger (end trace).
// (R14) Writing 0 to arm or enable ends the run at once.
// (R15) Valid count cleared at run start, reports 0 to 8 words.
// (R16) Reading the FIFO never decrements the valid count.
// (R17) Host keeps its own tally of FIFO words already read.
// (R18) Enable cannot be set while the device is secured.
// (R19) Break request at trigger (end trace) or FIFO full (begin).
// (R20) Eight-word FIFO; count saturates at eight in circular filling.
// (R21) All fields reset to zero, debugger disarmed.
`timescale 1ns/100ps
module dtt_trace_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cpu_access,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_read,
   input wire logic [7:0] cpu_data,
   input wire logic cpu_exec,
   input wire logic [15:0] cpu_exec_addr,
   input wire logic cpu_cof,
   input wire logic mcu_secure,
   output logic break_req,
   output logic break_tag
);
   import dtt_pkg::*;

   logic [7:0] ctrl_q;
   logic [7:0] trig_q;
   logic [15:0] cmpa_q;
   logic [15:0] cmpb_q;
   logic aw_got_q, w_got_q, bvalid_q, arready_q, rvalid_q;
   logic awready_q, wready_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   dtt_run_e run_q;
   logic af_q, bf_q, seen_a_q;
   logic [15:0] fifo_mem [FIFO_DEPTH];
   logic [2:0] wr_ptr_q, rd_ptr_q;
   logic [3:0] cnt_q;
   logic brk_q, brk_tag_q;

   logic wr_do, rd_do;
   logic wr_ctrl, wr_trig;
   logic en_new, arm_new, run_start, run_stop;
   logic [3:0] mode;
   logic ev_mode, begin_eff, running;
   logic [15:0] cmp_addr;
   logic cmp_valid, cmp_rw;
   logic hit_a, hit_b, ge_a, le_b, lt_a, gt_b;
   logic data_eq, trig_hit, store, run_done;
   logic [15:0] store_word;
   logic [7:0] status;
   logic [31:0] rd_mux;
   logic rd_ok;

   // Bus handshake outputs straight from flops
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign break_req = brk_q;
   assign break_tag = brk_tag_q;

   // Write address and data captured in either order
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else if (wr_do)
      begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   assign wr_do = aw_got_q && w_got_q && !bvalid_q;

   // Ready flops track next held and answer state of each half
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
      end
      else
      begin
         awready_q <= !wr_do && !(bvalid_q && !s_axi_bready) &&
            !(aw_got_q || (s_axi_awvalid && awready_q));
         wready_q <= !wr_do && !(bvalid_q && !s_axi_bready) &&
            !(w_got_q || (s_axi_wvalid && wready_q));
      end
   end

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else if (wr_do)
      begin
         bvalid_q <= 1'b1;
         case (awaddr_q)
            OFS_CTRL, OFS_TRIG, OFS_STAT, OFS_CMPA, OFS_CMPB, OFS_FIFO:
               bresp_q <= RESP_OKAY;
            default:
               bresp_q <= RESP_SLVERR;
         endcase
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // Control write decode, secure lockout on enable
   always_comb
   begin
      wr_ctrl = wr_do && (awaddr_q == OFS_CTRL) && wstrb_q[0];
      wr_trig = wr_do && (awaddr_q == OFS_TRIG) && wstrb_q[0];
      en_new = wdata_q[CTL_EN] && !mcu_secure; // see R18
      arm_new = wdata_q[CTL_ARM] && en_new; // see R12
      run_start = wr_ctrl && arm_new && !ctrl_q[CTL_ARM];
      run_stop = wr_ctrl && !arm_new; // see R14
   end

   // Control register; run end clears arm
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         ctrl_q <= CTRL_RST; // see R21
      else if (wr_ctrl)
      begin
         ctrl_q <= wdata_q[7:0];
         ctrl_q[CTL_EN] <= en_new;
         ctrl_q[CTL_ARM] <= arm_new && !run_done;
      end
      else if (run_done)
         ctrl_q[CTL_ARM] <= 1'b0; // see R12
   end

   // Trigger config and comparators, locked while armed
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         trig_q <= TRIG_RST;
         cmpa_q <= CMP_RST;
         cmpb_q <= CMP_RST;
      end
      else if (!ctrl_q[CTL_ARM] && wr_do)
      begin
         if (wr_trig)
            trig_q <= wdata_q[7:0] & TRG_WMASK; // see R1, R2
         if (awaddr_q == OFS_CMPA)
         begin
            if (wstrb_q[0])
               cmpa_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1])
               cmpa_q[15:8] <= wdata_q[15:8];
         end
         if (awaddr_q == OFS_CMPB)
         begin
            if (wstrb_q[0])
               cmpb_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1])
               cmpb_q[15:8] <= wdata_q[15:8];
         end
      end
   end

   // Compare source: executed opcode or any access
   always_comb
   begin
      mode = trig_q[3:0];
      if (trig_q[TRG_QUAL])
      begin
         cmp_addr = cpu_exec_addr; // see R3
         cmp_valid = cpu_exec;
         cmp_rw = 1'b1;
      end
      else
      begin
         cmp_addr = cpu_addr;
         cmp_valid = cpu_access;
         cmp_rw = cpu_read;
      end
   end

   dtt_addr_cmp u_cmp_a (
      .cmp_val(cmpa_q),
      .addr(cmp_addr),
      .valid(cmp_valid),
      .rw(cmp_rw),
      .rw_en(ctrl_q[CTL_RWAEN]),
      .rw_val(ctrl_q[CTL_RWA]),
      .hit(hit_a),
      .at_or_above(ge_a),
      .at_or_below()
   );

   dtt_addr_cmp u_cmp_b (
      .cmp_val(cmpb_q),
      .addr(cmp_addr),
      .valid(cmp_valid),
      .rw(cmp_rw),
      .rw_en(ctrl_q[CTL_RWBEN]),
      .rw_val(ctrl_q[CTL_RWB]),
      .hit(hit_b),
      .at_or_above(),
      .at_or_below(le_b)
   );

   // Trigger decode per mode
   always_comb
   begin
      data_eq = cpu_data == cmpb_q[7:0];
      lt_a = cmp_valid && !ge_a;
      gt_b = cmp_valid && !le_b;
      ev_mode = (mode == MODE_EV_B) || (mode == MODE_A_EV_B);
      begin_eff = ev_mode || trig_q[TRG_BEGIN]; // see R4, R5
      running = run_q != RUN_IDLE;
      case (mode) // see R6
         MODE_A: trig_hit = hit_a;
         MODE_A_OR_B: trig_hit = hit_a || hit_b;
         MODE_A_THEN_B: trig_hit = seen_a_q && hit_b;
         MODE_EV_B: trig_hit = 1'b1;
         MODE_A_EV_B: trig_hit = hit_a;
         MODE_A_AND_D: trig_hit = hit_a && data_eq;
         MODE_A_NOT_D: trig_hit = hit_a && !data_eq;
         MODE_INSIDE: trig_hit = ge_a && le_b; // see R7
         MODE_OUTSIDE: trig_hit = lt_a || gt_b; // see R7
         default: trig_hit = 1'b0;
      endcase
   end

   // What goes into the FIFO this cycle
   always_comb
   begin
      if (ev_mode)
      begin
         store = (run_q == RUN_STORE) && hit_b;
         store_word = {8'h00, cpu_data};
      end
      else
      begin
         store = cpu_cof && (run_q == RUN_STORE ||
                 (run_q == RUN_SEEK && !begin_eff && !trig_hit));
         store_word = cpu_exec_addr;
      end
      run_done = running && !run_stop &&
         ((run_q == RUN_STORE && store && cnt_q == CNT_FULL - 4'h1) ||
          (run_q == RUN_SEEK && !begin_eff && trig_hit)); // see R13
   end

   // Run sequencing
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         run_q <= RUN_IDLE;
      else if (run_stop || run_done)
         run_q <= RUN_IDLE; // see R14
      else
      begin
         case (run_q)
            RUN_IDLE:
               if (run_start)
                  run_q <= RUN_SEEK;
            RUN_SEEK:
               if (begin_eff && trig_hit)
                  run_q <= RUN_STORE; // see R4
            RUN_STORE:
               run_q <= RUN_STORE;
            default:
               run_q <= RUN_IDLE;
         endcase
      end
   end

   // Match flags; the start clear wins over a hit
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         af_q <= 1'b0;
         bf_q <= 1'b0;
         seen_a_q <= 1'b0;
      end
      else if (run_start)
      begin
         af_q <= 1'b0; // see R9
         bf_q <= 1'b0; // see R10
         seen_a_q <= 1'b0;
      end
      else if (running)
      begin
         if (hit_a)
         begin
            af_q <= 1'b1; // see R9
            seen_a_q <= 1'b1;
         end
         if (hit_b)
            bf_q <= 1'b1; // see R10
      end
   end

   // Trace storage and valid count
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wr_ptr_q <= 3'h0;
         cnt_q <= 4'h0;
      end
      else if (run_start)
      begin
         wr_ptr_q <= 3'h0;
         cnt_q <= 4'h0; // see R15
      end
      else if (store && !run_stop)
      begin
         fifo_mem[wr_ptr_q] <= store_word;
         wr_ptr_q <= wr_ptr_q + 3'h1;
         if (cnt_q != CNT_FULL)
            cnt_q <= cnt_q + 4'h1; // see R20
      end
   end

   // Read pointer: oldest word at run end, advances on idle reads
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rd_ptr_q <= 3'h0;
      else if (run_done || run_stop)
         rd_ptr_q <= wr_ptr_q - cnt_q[2:0];
      else if (rd_do && s_axi_araddr == OFS_FIFO && !ctrl_q[CTL_ARM])
         rd_ptr_q <= rd_ptr_q + 3'h1; // see R16
   end

   // Break request pulse on run completion
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         brk_q <= 1'b0;
         brk_tag_q <= 1'b0;
      end
      else
      begin
         brk_q <= run_done && ctrl_q[CTL_BRK]; // see R19
         brk_tag_q <= run_done && ctrl_q[CTL_BRK] && ctrl_q[CTL_TAG];
      end
   end

   // Read mux; status built live, writes never reach it
   always_comb
   begin
      status = 8'h00;
      status[STS_AF] = af_q;
      status[STS_BF] = bf_q;
      status[STS_ARMED_FLAG] = ctrl_q[CTL_ARM] && ctrl_q[CTL_EN]; // see R11
      status[3:0] = cnt_q; // see R8
      rd_ok = 1'b1;
      case (s_axi_araddr)
         OFS_CTRL: rd_mux = {24'h000000, ctrl_q};
         OFS_TRIG: rd_mux = {24'h000000, trig_q}; // see R1
         OFS_STAT: rd_mux = {24'h000000, status};
         OFS_CMPA: rd_mux = {16'h0000, cmpa_q};
         OFS_CMPB: rd_mux = {16'h0000, cmpb_q};
         OFS_FIFO: rd_mux = {16'h0000, fifo_mem[rd_ptr_q]};
         default:
         begin
            rd_mux = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   assign rd_do = s_axi_arvalid && arready_q;

   // Read channel, one cycle after the address is taken
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end
      else if (rd_do)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q)
      begin
         if (s_axi_rready)
         begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
      else
         arready_q <= 1'b1;
   end

   default clocking dcb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_TRIG_LOCK: assert property ( // see R1
      wr_trig && ctrl_q[CTL_ARM] |=> $stable(trig_q))
      else $error("trigger config changed while armed");

   AST_TRIG_RSV: assert property ( // see R2
      rd_do && s_axi_araddr == OFS_TRIG |=> rdata_q[5:4] == 2'b00)
      else $error("reserved trigger bits not zero");

   AST_STAT_RO: assert property ( // see R8
      wr_do && awaddr_q == OFS_STAT && !running |=>
      $stable(cnt_q) && $stable(af_q) && $stable(bf_q))
      else $error("status changed by a write");

   AST_START_CLR: assert property ( // see R9
      run_start |=> cnt_q == 4'h0 && !af_q && !bf_q && run_q == RUN_SEEK)
      else $error("run start did not clear status");

   AST_SECURE: assert property ( // see R18
      $rose(ctrl_q[CTL_EN]) |-> !$past(mcu_secure))
      else $error("enable set while secured");

   AST_DONE_DISARM: assert property ( // see R12
      run_done |=> !ctrl_q[CTL_ARM] && run_q == RUN_IDLE)
      else $error("run end left debugger armed");

   AST_END_TRACE: assert property ( // see R13
      run_q == RUN_SEEK && !begin_eff && trig_hit && !run_stop
      |=> run_q == RUN_IDLE)
      else $error("end trace did not stop on trigger");

   AST_NO_TRIG: assert property ( // see R6
      mode > MODE_OUTSIDE |-> !trig_hit)
      else $error("reserved mode produced a trigger");

   AST_CNT_MAX: assert property ( // see R20
      cnt_q == CNT_FULL && store |=> cnt_q == CNT_FULL)
      else $error("valid count passed eight");

   AST_BREAK: assert property ( // see R19
      $rose(brk_q) |-> $past(run_done) && $past(ctrl_q[CTL_BRK]))
      else $error("break request without run end");
endmodule // dtt_trace_top

// ### test/dtt_cpu_model.sv
// CPU bus and opcode tracking model that feeds the trigger block
`timescale 1ns/100ps
module dtt_cpu_model (
   input wire logic clk,
   output logic cpu_access,
   output logic [15:0] cpu_addr,
   output logic cpu_read,
   output logic [7:0] cpu_data,
   output logic cpu_exec,
   output logic [15:0] cpu_exec_addr,
   output logic cpu_cof
);
   // Quiet bus at time zero
   initial
   begin
      cpu_access = 1'b0;
      cpu_addr = 16'h0000;
      cpu_read = 1'b1;
      cpu_data = 8'h00;
      cpu_exec = 1'b0;
      cpu_exec_addr = 16'h0000;
      cpu_cof = 1'b0;
   end

   // Run n cycles at rising addresses, then one idle cycle
   task automatic step(input logic [15:0] a, input logic acc,
      input logic ex, input logic cof, input int n);
      for (int i = 0; i < n; i++)
      begin
         cpu_access <= acc;
         cpu_addr <= a + 16'(i);
         cpu_data <= a[7:0];
         cpu_exec <= ex;
         cpu_exec_addr <= a + 16'(i);
         cpu_cof <= cof;
         @(posedge clk);
      end
      // Idle lines show the inverse so stale values never match
      cpu_access <= 1'b0;
      cpu_addr <= ~a;
      cpu_data <= ~a[7:0];
      cpu_exec <= 1'b0;
      cpu_exec_addr <= ~a;
      cpu_cof <= 1'b0;
      @(posedge clk);
   endtask
endmodule // dtt_cpu_model

// ### test/tb.sv
// Self-checking bench for the debug trigger and trace block
`timescale 1ns/100ps
module tb;
   import dtt_pkg::*;
   logic clk, rst_b, mcu_secure;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp;
   logic cpu_access, cpu_read, cpu_exec, cpu_cof, break_req, break_tag;
   logic [15:0] cpu_addr, cpu_exec_addr;
   logic [7:0] cpu_data;
   int error_cnt, cmp_count, cyc, brk_cnt, tag_cnt;

   dtt_trace_top u_dut (.clk(clk), .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .cpu_access(cpu_access),
      .cpu_addr(cpu_addr), .cpu_read(cpu_read), .cpu_data(cpu_data),
      .cpu_exec(cpu_exec), .cpu_exec_addr(cpu_exec_addr),
      .cpu_cof(cpu_cof), .mcu_secure(mcu_secure),
      .break_req(break_req), .break_tag(break_tag));

   dtt_cpu_model u_cpu (.clk(clk), .cpu_access(cpu_access),
      .cpu_addr(cpu_addr), .cpu_read(cpu_read), .cpu_data(cpu_data),
      .cpu_exec(cpu_exec), .cpu_exec_addr(cpu_exec_addr),
      .cpu_cof(cpu_cof));

   // Clock at 50 MHz
   always #10 clk = ~clk;

   // Break pulse counters and hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (break_req === 1'b1) brk_cnt++;
      if (break_tag === 1'b1) tag_cnt++;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready === 1'b1)
         begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      wr_resp = s_axi_bresp;
   endtask

   // Read one word and its response code
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task automatic rd_mask(input logic [7:0] a, input logic [31:0] mk,
      input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(what, exp, d & mk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
      input string what);
      rd_mask(a, 32'hffffffff, exp, what);
   endtask

   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      rd_chk(OFS_CTRL, 32'h0, "ctrl reset");
      rd_chk(OFS_TRIG, 32'h0, "trig reset");
      rd_chk(OFS_STAT, 32'h0, "stat reset");
      axi_rd(8'h18, d, r);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("unmapped data", 32'h0, d);
      wr(8'h18, 32'hff);
      chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
   endtask

   task automatic t_trig_cfg();
      wr(OFS_TRIG, 32'hff);
      chk("wr resp", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
      rd_chk(OFS_TRIG, 32'hcf, "trig fixed bits");
      wr(OFS_CTRL, 32'hc0);
      wr(OFS_TRIG, 32'h01);
      rd_chk(OFS_TRIG, 32'hcf, "trig while armed");
      wr(OFS_STAT, 32'hff);
      rd_chk(OFS_STAT, 32'h20, "stat armed");
      wr(OFS_CTRL, 32'h00);
      rd_chk(OFS_STAT, 32'h00, "stat disabled");
      mcu_secure <= 1'b1;
      wr(OFS_CTRL, 32'h80);
      rd_chk(OFS_CTRL, 32'h00, "enable when secure");
      mcu_secure <= 1'b0;
   endtask

   task automatic t_end_trace();
      int b0;
      wr(OFS_CMPA, 32'h1234);
      wr(OFS_CMPB, 32'h4000);
      wr(OFS_TRIG, 32'h00);
      b0 = brk_cnt;
      wr(OFS_CTRL, 32'hd0);
      u_cpu.step(16'h2000, 1'b0, 1'b1, 1'b1, 10);
      u_cpu.step(16'h1234, 1'b1, 1'b0, 1'b0, 1);
      rd_chk(OFS_STAT, 32'h88, "stat end trace");
      rd_chk(OFS_CTRL, 32'h90, "ctrl arm cleared");
      chk("end breaks", 32'd1, 32'(brk_cnt - b0));
      // Host walks a fixed eight words, oldest first
      for (int i = 0; i < 8; i++)
         rd_chk(OFS_FIFO, 32'h2002 + i, "fifo word");
      wr(OFS_STAT, 32'h00);
      rd_chk(OFS_STAT, 32'h88, "count after reads");
   endtask

   task automatic t_begin_trace();
      int b0, t0;
      wr(OFS_TRIG, 32'h40);
      b0 = brk_cnt;
      t0 = tag_cnt;
      wr(OFS_CTRL, 32'hf0);
      rd_chk(OFS_STAT, 32'h20, "stat run start");
      u_cpu.step(16'h3000, 1'b0, 1'b1, 1'b1, 2);
      u_cpu.step(16'h1234, 1'b1, 1'b0, 1'b0, 1);
      rd_chk(OFS_STAT, 32'ha0, "stat after begin");
      u_cpu.step(16'h3100, 1'b0, 1'b1, 1'b1, 8);
      rd_chk(OFS_STAT, 32'h88, "stat fifo full");
      chk("begin breaks", 32'd1, 32'(brk_cnt - b0));
      chk("begin tags", 32'd1, 32'(tag_cnt - t0));
   endtask

   task automatic t_stop_qual();
      wr(OFS_TRIG, 32'h00);
      wr(OFS_CTRL, 32'hc0);
      u_cpu.step(16'h2200, 1'b0, 1'b1, 1'b1, 3);
      wr(OFS_CTRL, 32'h80);
      rd_chk(OFS_STAT, 32'h03, "stat manual stop");
      wr(OFS_TRIG, 32'h80);
      wr(OFS_CTRL, 32'hc0);
      u_cpu.step(16'h1234, 1'b1, 1'b0, 1'b0, 1);
      rd_mask(OFS_STAT, 32'h20, 32'h20, "qualified access");
      u_cpu.step(16'h1234, 1'b0, 1'b1, 1'b0, 1);
      rd_mask(OFS_STAT, 32'h20, 32'h00, "qualified exec");
      wr(OFS_CTRL, 32'h80);
   endtask

   task automatic t_modes();
      logic [7:0] m [12];
      logic [15:0] ad [12];
      logic [31:0] ex [12];
      m = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h07, 8'h08, 8'h08, 8'h09, 8'h0f,
         8'h04, 8'h05, 8'h06};
      ad = '{16'h4000, 16'h4000, 16'h4000, 16'h2000, 16'h4000, 16'h2000,
         16'h4001, 16'h1234, 16'h1234, 16'h1234, 16'h1234, 16'h1234};
      ex = '{32'h40, 32'h60, 32'h60, 32'h0, 32'h40, 32'h20, 32'h0, 32'ha0,
         32'ha0, 32'ha0, 32'ha0, 32'h80};
      // Match flags and armed bit after one access show what the mode did
      for (int i = 0; i < 12; i++)
      begin
         wr(OFS_TRIG, {24'h0, m[i]});
         wr(OFS_CTRL, 32'hc0);
         u_cpu.step(ad[i], 1'b1, 1'b0, 1'b0, 1);
         rd_mask(OFS_STAT, 32'he0, ex[i], "flags");
         wr(OFS_CTRL, 32'h80);
      end
   endtask

   // Reset, then the scenarios in turn
   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      mcu_secure = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_trig_cfg();
      t_end_trace();
      t_begin_trace();
      t_stop_qual();
      t_modes();
      test_done();
   end
endmodule // tb
